/* rtl/bas_shifter.sv */
// Bit array shifter with control elements, data file and index register.
// Assumes an AXI4-Lite master on the one 100 MHz clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bas_shifter #(
  parameter int NUM_CTRL = 4,
  parameter int FILE_WORDS = 105
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic IRQ_OUT
);
  localparam int CW = (NUM_CTRL > 1) ? $clog2(NUM_CTRL) : 1;
  localparam int WW = $clog2(FILE_WORDS + 1);
  localparam logic [15:0] FILE_BITS = 16'(FILE_WORDS * 16);
  // Parameter sanity
  if (NUM_CTRL < 1 || NUM_CTRL > 16) begin : g_bad_ctrl
    $error("NUM_CTRL must be 1 to 16");
  end
  if (FILE_WORDS < 1 || FILE_WORDS > 4095) begin : g_bad_file
    $error("FILE_WORDS must be 1 to 4095");
  end

  bas_pkg::bas_state_t state;
  logic [15:0] mem [FILE_WORDS];
  logic [15:0] ctl_stat [NUM_CTRL];
  logic [15:0] ctl_len [NUM_CTRL];
  logic [15:0] index_reg;
  logic major;
  logic [CW-1:0] csel;
  logic [WW-1:0] daddr;
  logic [bas_pkg::EV_NUM-1:0] irq_en;
  logic [bas_pkg::EV_NUM-1:0] irq_stat;
  logic [bas_pkg::EV_NUM-1:0] ev;
  logic [bas_pkg::EV_NUM-1:0] irq_clr;
  logic aw_got, w_got, ar_got;
  logic [7:0] aw_addr, ar_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [WW-1:0] wi, last_wi;
  logic [3:0] last_pos;
  logic dir_up, carry;
  logic [CW-1:0] cur;

  // Register read value for a byte address
  function automatic logic [31:0] reg_rd(input logic [7:0] a);
    case (a)
      bas_pkg::OFF_STATUS: reg_rd = {30'h0, major, state == bas_pkg::ST_SHIFT};
      bas_pkg::OFF_INDEX: reg_rd = {16'h0, index_reg};
      bas_pkg::OFF_CSEL: reg_rd = 32'(csel);
      bas_pkg::OFF_CSTAT: reg_rd = {16'h0, ctl_stat[csel]};
      bas_pkg::OFF_CLEN: reg_rd = {16'h0, ctl_len[csel]};
      bas_pkg::OFF_DADDR: reg_rd = 32'(daddr);
      bas_pkg::OFF_DDATA: reg_rd = (32'(daddr) < FILE_WORDS) ? {16'h0, mem[daddr]} : 32'h0;
      bas_pkg::OFF_IRQ_STAT: reg_rd = 32'(irq_stat);
      bas_pkg::OFF_IRQ_EN: reg_rd = 32'(irq_en);
      default: reg_rd = 32'h0;
    endcase
  endfunction

  // Address is a mapped register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= bas_pkg::OFF_IRQ_EN);
  endfunction

  // Bus write decode, readback of the addressed register (a process, so it tracks contents), lane merge
  logic idle, wr_exec, rd_exec;
  logic [31:0] wd, aw_rd;
  always_comb aw_rd = reg_rd(aw_addr);
  assign idle = (state == bas_pkg::ST_IDLE);
  assign wr_exec = aw_got && w_got && !S_AXI_BVALID_OUT && idle;
  assign rd_exec = ar_got && !S_AXI_RVALID_OUT && idle;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wd[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : aw_rd[8*b +: 8];
  end
  logic wr_ok;
  assign wr_ok = wr_exec && reg_hit(aw_addr);
  assign irq_clr = (wr_ok && aw_addr == bas_pkg::OFF_IRQ_CLR) ? wd[bas_pkg::EV_NUM-1:0] : '0;

  // Evaluation command decode
  bas_pkg::bas_eval_t evc;
  logic eval_go, ctl_ok, is_up, is_shift, is_seq, rise;
  logic [CW-1:0] ev_ctl;
  logic [15:0] cur_len, len_m1;
  logic len_neg, len_zero, len_over;
  assign evc = bas_pkg::bas_eval_t'(wd);
  assign ctl_ok = 32'(evc.ctrl) < NUM_CTRL;
  assign eval_go = wr_ok && aw_addr == bas_pkg::OFF_EVAL && ctl_ok;
  assign ev_ctl = evc.ctrl[CW-1:0];
  assign is_up = evc.code == bas_pkg::FC_SHIFT_UP;
  assign is_shift = is_up || evc.code == bas_pkg::FC_SHIFT_DOWN;
  assign is_seq = evc.code == bas_pkg::FC_SEQ_OUT || evc.code == bas_pkg::FC_SEQ_CMP;
  assign rise = evc.rung && !ctl_stat[ev_ctl][bas_pkg::EN_BIT];
  assign cur_len = ctl_len[ev_ctl];
  assign len_neg = cur_len[15];
  assign len_zero = cur_len == 16'h0000;
  assign len_over = !len_neg && (cur_len > bas_pkg::MAX_BITS || cur_len > FILE_BITS);
  assign len_m1 = cur_len - 16'h0001;
  logic go_shift, go_zero, go_neg, go_major;
  assign go_neg = eval_go && is_shift && rise && len_neg;
  assign go_major = eval_go && is_shift && rise && len_over;
  assign go_zero = eval_go && is_shift && rise && len_zero;
  assign go_shift = eval_go && is_shift && rise && !len_neg && !len_over && !len_zero;

  // Word step of the running shift
  logic [15:0] w_new;
  logic c_new, step_last, step_end;
  assign step_last = (wi == last_wi);
  assign step_end = dir_up ? step_last : (wi == '0);
  bas_word_shift u_step (
    .word_in(mem[wi]),
    .dir_up_in(dir_up),
    .carry_in(carry),
    .is_last_in(step_last),
    .last_pos_in(last_pos),
    .word_out(w_new),
    .carry_out(c_new)
  );

  // Write address and data channels
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN) begin
        S_AXI_AWREADY_OUT <= 1'b0;
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WREADY_OUT && S_AXI_WVALID_IN) begin
        S_AXI_WREADY_OUT <= 1'b0;
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      if (wr_exec) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b1;
      end
    end
  end

  // Write response; bad address or evaluation control index answers SLVERR
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= bas_pkg::RESP_OKAY;
    end else if (wr_exec) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT <= (reg_hit(aw_addr) && (aw_addr != bas_pkg::OFF_EVAL || ctl_ok)) ?
                         bas_pkg::RESP_OKAY : bas_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Read channels
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0;
      S_AXI_RRESP_OUT <= bas_pkg::RESP_OKAY;
      ar_got <= 1'b0;
      ar_addr <= 8'h00;
    end else begin
      if (S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN) begin
        S_AXI_ARREADY_OUT <= 1'b0;
        ar_got <= 1'b1;
        ar_addr <= S_AXI_ARADDR_IN;
      end
      if (rd_exec) begin
        ar_got <= 1'b0;
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT <= reg_hit(ar_addr) ? reg_rd(ar_addr) : 32'h0;
        S_AXI_RRESP_OUT <= reg_hit(ar_addr) ? bas_pkg::RESP_OKAY : bas_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
        S_AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

  // Plain software registers
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      csel <= '0;
      daddr <= '0;
      irq_en <= '0;
    end else if (wr_ok) begin
      if (aw_addr == bas_pkg::OFF_CSEL && 32'(wd[3:0]) < NUM_CTRL) csel <= wd[CW-1:0];
      if (aw_addr == bas_pkg::OFF_DADDR) daddr <= wd[WW-1:0];
      if (aw_addr == bas_pkg::OFF_IRQ_EN) irq_en <= wd[bas_pkg::EV_NUM-1:0];
    end
  end

  // Data file: bus writes when idle, shift steps when running
  always_ff @(posedge REF_CLK_IN) begin
    if (state == bas_pkg::ST_SHIFT) begin
      mem[wi] <= w_new;
    end else if (wr_ok && aw_addr == bas_pkg::OFF_DDATA && 32'(daddr) < FILE_WORDS) begin
      mem[daddr] <= wd[15:0];
    end
  end

  // Shift sequencing, one word per clock, busy holds off the bus
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= bas_pkg::ST_IDLE;
      wi <= '0;
      last_wi <= '0;
      last_pos <= 4'h0;
      dir_up <= 1'b1;
      carry <= 1'b0;
      cur <= '0;
    end else begin
      unique case (state)
        bas_pkg::ST_IDLE: begin
          if (eval_go) cur <= ev_ctl;
          if (go_shift) begin
            state <= bas_pkg::ST_SHIFT;
            dir_up <= is_up;
            carry <= evc.src;
            last_wi <= len_m1[WW+3:4];
            last_pos <= len_m1[3:0];
            wi <= is_up ? '0 : len_m1[WW+3:4];
          end
        end
        bas_pkg::ST_SHIFT: begin
          carry <= c_new;
          if (step_end) begin
            state <= bas_pkg::ST_IDLE;
          end else begin
            wi <= dir_up ? wi + 1'b1 : wi - 1'b1;
          end
        end
      endcase
    end
  end

  // Control elements, index register and major fault
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctl_stat[i] <= bas_pkg::STAT_RESET;
        ctl_len[i] <= bas_pkg::LEN_RESET;
      end
      index_reg <= 16'h0000;
      major <= 1'b0;
    end else begin
      if (wr_ok && aw_addr == bas_pkg::OFF_CSTAT) ctl_stat[csel] <= wd[15:0];
      if (wr_ok && aw_addr == bas_pkg::OFF_CLEN) ctl_len[csel] <= wd[15:0];
      if (wr_ok && aw_addr == bas_pkg::OFF_STATUS && wd[bas_pkg::ST_MAJOR_BIT]) major <= 1'b0;
      if (eval_go && is_shift && !evc.rung) begin
        ctl_stat[ev_ctl][bas_pkg::EN_BIT] <= 1'b0;
        ctl_stat[ev_ctl][bas_pkg::DN_BIT] <= 1'b0;
        ctl_stat[ev_ctl][bas_pkg::ER_BIT] <= 1'b0;
      end
      if (eval_go && is_shift && rise) ctl_stat[ev_ctl][bas_pkg::EN_BIT] <= 1'b1;
      if (go_neg) ctl_stat[ev_ctl][bas_pkg::ER_BIT] <= 1'b1;
      if (go_major) major <= 1'b1;
      if (go_zero) begin
        ctl_stat[ev_ctl][bas_pkg::UL_BIT] <= evc.src;
        ctl_stat[ev_ctl][bas_pkg::DN_BIT] <= 1'b1;
      end
      if (go_zero || go_shift) index_reg <= 16'h0000;
      if (eval_go && is_seq && evc.rung) index_reg <= evc.pos;
      if (state == bas_pkg::ST_SHIFT && step_end) begin
        ctl_stat[cur][bas_pkg::UL_BIT] <= c_new;
        ctl_stat[cur][bas_pkg::DN_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt events
  assign ev[bas_pkg::EV_DONE] = go_zero || (state == bas_pkg::ST_SHIFT && step_end);
  assign ev[bas_pkg::EV_FAULT] = go_neg;
  assign ev[bas_pkg::EV_MAJOR] = go_major;
  bas_irq #(.N(bas_pkg::EV_NUM)) u_irq (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .event_in(ev),
    .clear_in(irq_clr),
    .enable_in(irq_en),
    .stat_out(irq_stat),
    .irq_out(IRQ_OUT)
  );

  // Checks on the shift behaviour
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_start_up;
    go_shift && is_up;
  endsequence
  sequence s_enter_shift;
    state == bas_pkg::ST_SHIFT && ctl_stat[cur][bas_pkg::EN_BIT];
  endsequence
  up_start_a: assert property (s_start_up |=> (s_enter_shift and dir_up))
    else $error("shift-up start did not set active flag and run");
  index_clear_a: assert property (go_shift || go_zero |=> index_reg == 16'h0000)
    else $error("index not cleared by shift");
  zero_len_a: assert property (go_zero |=> ctl_stat[cur][bas_pkg::UL_BIT] == $past(evc.src)
    && state == bas_pkg::ST_IDLE)
    else $error("zero length did not copy source to shifted-out flag");
  seq_index_a: assert property (eval_go && is_seq && evc.rung |=> index_reg == $past(evc.pos))
    else $error("sequencer did not load index");
  neg_len_a: assert property (go_neg |=> ctl_stat[cur][bas_pkg::ER_BIT] && idle)
    else $error("negative length did not set fault flag");
  rung_low_a: assert property (eval_go && is_shift && !evc.rung |=>
    !ctl_stat[cur][bas_pkg::EN_BIT] && !ctl_stat[cur][bas_pkg::DN_BIT]
    && !ctl_stat[cur][bas_pkg::ER_BIT])
    else $error("rung false did not clear flags");
  shift_ends_a: assert property ($rose(state == bas_pkg::ST_SHIFT) |-> ##[1:110]
    (idle && ctl_stat[cur][bas_pkg::DN_BIT]))
    else $error("shift did not finish with completion flag");
  major_a: assert property (go_major |=> major && idle && irq_stat[bas_pkg::EV_MAJOR])
    else $error("overlong length did not raise major fault");
  last_word_a: assert property (state == bas_pkg::ST_SHIFT && step_last && last_pos != 4'hf |=>
    (mem[$past(wi)] >> ($past(last_pos) + 4'h1)) == 16'h0000)
    else $error("bits past array end not cleared");
endmodule // bas_shifter
`default_nettype wire

/* rtl/bas_pkg.sv */
// Shared constants and types for the bit array shifter.
// Assumes a 32-bit AXI4-Lite register bus and 16-bit data words.
package bas_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_EVAL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INDEX = 8'h08;
  localparam logic [7:0] OFF_CSEL = 8'h0c;
  localparam logic [7:0] OFF_CSTAT = 8'h10;
  localparam logic [7:0] OFF_CLEN = 8'h14;
  localparam logic [7:0] OFF_DADDR = 8'h18;
  localparam logic [7:0] OFF_DDATA = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN = 8'h28;
  // Control element status bit positions
  localparam int EN_BIT = 15;
  localparam int DN_BIT = 13;
  localparam int ER_BIT = 11;
  localparam int UL_BIT = 10;
  // Status register bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MAJOR_BIT = 1;
  // Event bit positions
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_MAJOR = 2;
  localparam int EV_NUM = 3;
  // Function codes
  localparam logic [7:0] FC_SHIFT_UP = 8'h96;
  localparam logic [7:0] FC_SHIFT_DOWN = 8'h97;
  localparam logic [7:0] FC_SEQ_OUT = 8'h98;
  localparam logic [7:0] FC_SEQ_CMP = 8'h99;
  // Limits, reset values and bus response codes
  localparam logic [15:0] MAX_BITS = 16'h0690;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] LEN_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Evaluation command word
  typedef struct packed {
    logic [15:0] pos;
    logic [1:0] rsvd;
    logic src;
    logic rung;
    logic [3:0] ctrl;
    logic [7:0] code;
  } bas_eval_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } bas_state_t;
endpackage

/* rtl/bas_word_shift.sv */
// One 16-bit word step of an array shift, purely combinational.
// Assumes the caller walks words upward for shift-up, downward for shift-down.
`timescale 1ns/1ps
`default_nettype none
module bas_word_shift (
  input wire logic [15:0] word_in,
  input wire logic dir_up_in,
  input wire logic carry_in,
  input wire logic is_last_in,
  input wire logic [3:0] last_pos_in,
  output logic [15:0] word_out,
  output logic carry_out
);
  logic [16:0] mask_wide;
  logic [15:0] mask;
  logic [15:0] up_word;
  logic [15:0] down_word;
  logic [15:0] ins_bit;
  // Bits above the last array bit are cleared in the last word
  assign mask_wide = (17'h00002 << last_pos_in) - 17'h00001;
  assign mask = is_last_in ? mask_wide[15:0] : 16'hffff;
  assign ins_bit = carry_in ? (16'h0001 << last_pos_in) : 16'h0000;
  assign up_word = {word_in[14:0], carry_in} & mask;
  assign down_word = is_last_in ? (((word_in & mask) >> 1) | ins_bit) : {carry_in, word_in[15:1]};
  assign word_out = dir_up_in ? up_word : down_word;
  assign carry_out = dir_up_in ? (is_last_in ? word_in[last_pos_in] : word_in[15]) : word_in[0];
endmodule // bas_word_shift
`default_nettype wire

/* rtl/bas_irq.sv */
// Sticky event status, enable mask and level interrupt.
// Assumes events and clears are one-cycle pulses on the block clock.
`timescale 1ns/1ps
`default_nettype none
module bas_irq #(
  parameter int N = 3
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] clear_in,
  input wire logic [N-1:0] enable_in,
  output logic [N-1:0] stat_out,
  output logic irq_out
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stat_out <= '0;
      irq_out <= 1'b0;
    end else begin
      stat_out <= (stat_out & ~clear_in) | event_in;
      irq_out <= |(((stat_out & ~clear_in) | event_in) & enable_in);
    end
  end
endmodule // bas_irq
`default_nettype wire

/* testbench/bas_scan_model.sv */
// Program scan model: issues register accesses to the shifter as an AXI4-Lite master.
// Assumes the shifter's slave on the same clock, one write or one read at a time.
`timescale 1ns/1ps
`default_nettype none
module bas_scan_model (
  input wire logic clk_in,
  output logic awvalid_out,
  output logic [7:0] awaddr_out,
  output logic wvalid_out,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic bready_out,
  output logic arvalid_out,
  output logic [7:0] araddr_out,
  output logic rready_out,
  input wire logic awready_in,
  input wire logic wready_in,
  input wire logic bvalid_in,
  input wire logic [1:0] bresp_in,
  input wire logic arready_in,
  input wire logic rvalid_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in
);
  // Idle bus at time zero
  initial begin
    awvalid_out = 1'b0;
    awaddr_out = 8'h00;
    wvalid_out = 1'b0;
    wdata_out = 32'h0;
    wstrb_out = 4'hf;
    bready_out = 1'b0;
    arvalid_out = 1'b0;
    araddr_out = 8'h00;
    rready_out = 1'b0;
  end
  // One write; each channel dropped, payload scrambled, once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    resp = 2'h3;
    @(posedge clk_in);
    awvalid_out <= 1'b1;
    awaddr_out <= a;
    wvalid_out <= 1'b1;
    wdata_out <= d;
    bready_out <= 1'b1;
    // Waits for the answer; only the bench watchdog ends a hang
    forever begin
      @(posedge clk_in);
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
      if (bvalid_in) begin
        resp = bresp_in;
        bready_out <= 1'b0;
        break;
      end
    end
  endtask
  // One read; data taken at the edge that shows the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    resp = 2'h3;
    d = 32'hx;
    @(posedge clk_in);
    arvalid_out <= 1'b1;
    araddr_out <= a;
    rready_out <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
      end
      if (rvalid_in) begin
        d = rdata_in;
        resp = rresp_in;
        rready_out <= 1'b0;
        break;
      end
    end
  endtask
endmodule // bas_scan_model
`default_nettype wire

/* testbench/bas_shifter_bench.sv */
// Self-checking bench for the bit array shifter, driven through the scan model.
// Assumes the shifter with default parameters: 4 control elements, 105 data words.
`timescale 1ns/1ps
`default_nettype none
module bas_shifter_bench;
  logic clk, rst_b, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, rot_d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, rot_r;
  int n_fail = 0;
  int num_checks = 0;
  bas_shifter u_bas_shifter (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(ws), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp), .IRQ_OUT(irq));
  bas_scan_model u_bas_scan_model (
    .clk_in(clk), .awvalid_out(awv), .awaddr_out(awa), .wvalid_out(wv), .wdata_out(wd),
    .wstrb_out(ws), .bready_out(br), .arvalid_out(arv), .araddr_out(ara), .rready_out(rr),
    .awready_in(awr), .wready_in(wr_r), .bvalid_in(bv), .bresp_in(bresp), .arready_in(arr),
    .rvalid_in(rv), .rdata_in(rdat), .rresp_in(rresp));
  // Verdict and end of run
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compare one data value
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  // Compare one bus response
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  // Register write with expected response
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = bas_pkg::RESP_OKAY);
    logic [1:0] r;
    u_bas_scan_model.wr(a, d, r);
    chk_resp(r, er);
  endtask
  // Register read, masked compare, expected response
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff,
                    input logic [1:0] er = bas_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    u_bas_scan_model.rd(a, d, r);
    chk_resp(r, er);
    chk_data(d & m, exp);
  endtask
  // Evaluate one operation
  task automatic ev(input logic [7:0] code, input logic [3:0] c, input logic rung, input logic src,
                    input logic [15:0] pos = 16'h0, input logic [1:0] er = bas_pkg::RESP_OKAY);
    bas_pkg::bas_eval_t e;
    e = '{pos: pos, rsvd: 2'h0, src: src, rung: rung, ctrl: c, code: code};
    w(bas_pkg::OFF_EVAL, e, er);
  endtask
  // Select element and set its length
  task automatic setlen(input logic [3:0] c, input logic [15:0] len);
    w(bas_pkg::OFF_CSEL, {28'h0, c});
    w(bas_pkg::OFF_CLEN, {16'h0, len});
  endtask
  // Read one data word
  task automatic rword(input logic [7:0] i, input logic [15:0] exp);
    w(bas_pkg::OFF_DADDR, {24'h0, i});
    rc(bas_pkg::OFF_DDATA, {16'h0, exp});
  endtask
  // Level interrupt seen a few cycles after a change
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge clk);
    chk_data({31'h0, irq}, {31'h0, exp});
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rc(bas_pkg::OFF_CSTAT, 32'h0);
    rc(bas_pkg::OFF_INDEX, 32'h0);
    ev(bas_pkg::FC_SEQ_OUT, 4'h3, 1'b1, 1'b0, 16'h0005);
    rc(bas_pkg::OFF_INDEX, 32'h5);
    ev(bas_pkg::FC_SEQ_CMP, 4'h3, 1'b1, 1'b0, 16'h0007);
    rc(bas_pkg::OFF_INDEX, 32'h7);
    // Array of 20 bits across two words, shifted up with a one
    w(bas_pkg::OFF_DADDR, 32'h0);
    w(bas_pkg::OFF_DDATA, 32'h8001);
    w(bas_pkg::OFF_DADDR, 32'h1);
    w(bas_pkg::OFF_DDATA, 32'hffff);
    setlen(4'h0, 16'd20);
    ev(bas_pkg::FC_SHIFT_UP, 4'h0, 1'b1, 1'b1);
    rword(8'h0, 16'h0003);
    rword(8'h1, 16'h000f);
    rc(bas_pkg::OFF_CSTAT, 32'ha400);
    rc(bas_pkg::OFF_INDEX, 32'h0);
    rc(bas_pkg::OFF_IRQ_STAT, 32'h1);
    chk_irq(1'b0);
    w(bas_pkg::OFF_IRQ_EN, 32'h7);
    chk_irq(1'b1);
    w(bas_pkg::OFF_IRQ_CLR, 32'h1);
    chk_irq(1'b0);
    // Held rung moves nothing, falling rung clears the flags except the shifted-out one
    ev(bas_pkg::FC_SHIFT_UP, 4'h0, 1'b1, 1'b1);
    rword(8'h0, 16'h0003);
    ev(bas_pkg::FC_SHIFT_UP, 4'h0, 1'b0, 1'b1);
    rc(bas_pkg::OFF_CSTAT, 32'h0400);
    // Shift down with a zero
    ev(bas_pkg::FC_SHIFT_DOWN, 4'h0, 1'b1, 1'b0);
    rword(8'h0, 16'h8001);
    rword(8'h1, 16'h0007);
    w(bas_pkg::OFF_CSEL, 32'h0);
    rc(bas_pkg::OFF_CSTAT, 32'ha400);
    ev(bas_pkg::FC_SHIFT_DOWN, 4'h0, 1'b0, 1'b0);
    // Zero length moves no data, copies the source and sets done
    setlen(4'h1, 16'h0);
    ev(bas_pkg::FC_SHIFT_UP, 4'h1, 1'b1, 1'b1);
    rc(bas_pkg::OFF_CSTAT, 32'ha400);
    rword(8'h0, 16'h8001);
    w(bas_pkg::OFF_CSEL, 32'h0);
    rc(bas_pkg::OFF_CSTAT, 32'h0400);
    // Negative length; shifted-out flag not relied on here
    setlen(4'h2, 16'hffff);
    ev(bas_pkg::FC_SHIFT_UP, 4'h2, 1'b1, 1'b0);
    rc(bas_pkg::OFF_CSTAT, 32'h0800, 32'h0800);
    rc(bas_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
    // Length one past the file end
    ev(bas_pkg::FC_SHIFT_UP, 4'h3, 1'b0, 1'b0);
    setlen(4'h3, 16'd1681);
    ev(bas_pkg::FC_SHIFT_UP, 4'h3, 1'b1, 1'b1);
    rc(bas_pkg::OFF_STATUS, 32'h2, 32'h2);
    rword(8'h0, 16'h8001);
    rc(bas_pkg::OFF_IRQ_STAT, 32'h4, 32'h4);
    w(bas_pkg::OFF_STATUS, 32'h2);
    rc(bas_pkg::OFF_STATUS, 32'h0, 32'h2);
    // Longest array that fits, index cleared by the shift
    ev(bas_pkg::FC_SEQ_OUT, 4'h3, 1'b1, 1'b0, 16'h0009);
    ev(bas_pkg::FC_SHIFT_UP, 4'h2, 1'b0, 1'b0);
    setlen(4'h2, 16'd1680);
    ev(bas_pkg::FC_SHIFT_UP, 4'h2, 1'b1, 1'b0);
    rc(bas_pkg::OFF_STATUS, 32'h0, 32'h2);
    rword(8'h0, 16'h0002);
    rc(bas_pkg::OFF_CSTAT, 32'h2000, 32'h2000);
    rc(bas_pkg::OFF_INDEX, 32'h0);
    // Rotate the 20-bit array up: program feeds the far-end bit 19 back in
    w(bas_pkg::OFF_DADDR, 32'h1);
    u_bas_scan_model.rd(bas_pkg::OFF_DDATA, rot_d, rot_r);
    chk_resp(rot_r, bas_pkg::RESP_OKAY);
    ev(bas_pkg::FC_SHIFT_UP, 4'h0, 1'b1, rot_d[3]);
    rword(8'h0, 16'h0005);
    rword(8'h1, 16'h000e);
    // Refused accesses and interrupt clear
    rc(8'h2c, 32'h0, 32'hffffffff, bas_pkg::RESP_SLVERR);
    ev(bas_pkg::FC_SHIFT_UP, 4'h5, 1'b1, 1'b0, 16'h0, bas_pkg::RESP_SLVERR);
    w(bas_pkg::OFF_IRQ_CLR, 32'h7);
    rc(bas_pkg::OFF_IRQ_STAT, 32'h0);
    chk_irq(1'b0);
    finish_test();
  end
endmodule // bas_shifter_bench
`default_nettype wire
